/* File: rtl/sbg_pkg.sv */
// Purpose: Shared constants for the serial baud generator
// Assumes: 32-bit APB, one register per aligned word
// Notes: Offsets below are byte addresses
package sbg_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
  localparam logic [7:0] ADDR_BAUD_CTRL = 8'h08;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_DIV_LOW = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // Field positions
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int WIDE_DIV_BIT = 3;
  localparam int STAT_LEVEL_BIT = 8;
  // Reset values (transmit shift empty flag reads high, receive control reads all zero)
  localparam logic [7:0] TX_CTRL_RESET = 8'h02;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_CTRL_RESET = 8'h40;
  localparam logic [7:0] DIV_RESET = 8'h00;
  // Last prescaler count for each divide factor (factor minus one)
  localparam logic [5:0] LAST_DIV64 = 6'h3f;
  localparam logic [5:0] LAST_DIV16 = 6'h0f;
  localparam logic [5:0] LAST_DIV4 = 6'h03;
  // Number of majority samples per bit
  localparam int VOTE_SAMPLES = 3;
endpackage

/* File: rtl/sbg_sample_if.sv */
// Purpose: Carries sample strobes and voted level between generator and voter
// Assumes: Single clock domain
// Notes: rx_sync is already synchronised
`timescale 1ns/1ps
interface sbg_sample_if;
  logic strobe;
  logic vote;
  logic rx_sync;
  logic level;
  modport gen (output strobe, output vote, output rx_sync, input level);
  modport voter (input strobe, input vote, input rx_sync, output level);
endinterface

/* File: rtl/sbg_voter.sv */
// Purpose: Three-sample majority detector for the receive pin
// Assumes: Strobes come three times per bit, vote on the third
// Notes: Level idles high after reset
`timescale 1ns/1ps
module sbg_voter (
  input wire logic clock_in,
  input wire logic reset_in,
  sbg_sample_if.voter smp
);
  logic [1:0] samples;
  logic majority;

  // Two earlier samples plus the current one
  assign majority = (samples[1] & samples[0]) | (samples[1] & smp.rx_sync) |
                    (samples[0] & smp.rx_sync);

  // Sample history and voted level
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      samples <= 2'h3;
      smp.level <= 1'b1;
    end else begin
      if (smp.strobe) begin
        samples <= {samples[0], smp.rx_sync};
      end
      if (smp.vote) begin
        smp.level <= majority;
      end
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_third_sample;
    smp.vote && smp.strobe;
  endsequence
  property p_majority;
    s_third_sample |=> smp.level == (($past(samples[1]) & $past(samples[0])) |
      ($past(samples[1]) & $past(smp.rx_sync)) | ($past(samples[0]) & $past(smp.rx_sync)));
  endproperty
  a_majority: assert property (p_majority) else $error("majority vote wrong");
  property p_level_hold;
    !smp.vote |=> $stable(smp.level);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level moved without vote");
endmodule

/* File: rtl/sbg_top.sv */
// Purpose: Baud rate generator with APB registers and receive majority sampling
// Assumes: clock_in is the device clock; APB master keeps protocol
// Notes: pready is always high; unmapped addresses answer pslverr
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module sbg_top #(
  parameter int DIV_W = 16
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_in,
  output logic baud_tick_out,
  output logic rx_level_out
);
  logic [7:0] transmit_control_status;
  logic [7:0] receive_control_status;
  logic [7:0] baud_control;
  logic [7:0] baud_divisor_high;
  logic [7:0] baud_divisor_low;
  logic [DIV_W-1:0] count;
  logic [5:0] prescale;
  logic rx_meta;
  logic rx_sync;
  logic baud_tick;
  sbg_sample_if smp ();

  // Divide factor choice, returned as factor minus one
  function automatic logic [5:0] factor_last(input logic sync, input logic wide,
                                             input logic fast);
    if (sync) begin
      factor_last = sbg_pkg::LAST_DIV4;
    end else if (wide && fast) begin
      factor_last = sbg_pkg::LAST_DIV4;
    end else if (wide || fast) begin
      factor_last = sbg_pkg::LAST_DIV16;
    end else begin
      factor_last = sbg_pkg::LAST_DIV64;
    end
  endfunction

  // Mode bits and divisor value
  wire sync_mode = transmit_control_status[sbg_pkg::SYNC_BIT];
  wire high_speed_select = transmit_control_status[sbg_pkg::HIGH_SPEED_BIT];
  wire wide_divisor_select = baud_control[sbg_pkg::WIDE_DIV_BIT];
  wire [DIV_W-1:0] div_n = wide_divisor_select ?
    DIV_W'({baud_divisor_high, baud_divisor_low}) : DIV_W'(baud_divisor_low);
  wire [5:0] last = factor_last(sync_mode, wide_divisor_select, high_speed_select);
  wire [5:0] mid = (last >> 1) + 6'h01;

  // Bus decode
  wire setup = psel_in && !penable_in;
  wire wr = psel_in && penable_in && pwrite_in;
  wire wr_tx = wr && paddr_in == sbg_pkg::ADDR_TX_CTRL;
  wire wr_rx = wr && paddr_in == sbg_pkg::ADDR_RX_CTRL;
  wire wr_bc = wr && paddr_in == sbg_pkg::ADDR_BAUD_CTRL;
  wire wr_hi = wr && paddr_in == sbg_pkg::ADDR_DIV_HIGH;
  wire wr_lo = wr && paddr_in == sbg_pkg::ADDR_DIV_LOW;
  wire wr_div = wr_hi || wr_lo;
  wire mapped = paddr_in == sbg_pkg::ADDR_TX_CTRL || paddr_in == sbg_pkg::ADDR_RX_CTRL ||
                paddr_in == sbg_pkg::ADDR_BAUD_CTRL || paddr_in == sbg_pkg::ADDR_DIV_HIGH ||
                paddr_in == sbg_pkg::ADDR_DIV_LOW || paddr_in == sbg_pkg::ADDR_STATUS;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;

  // Read mux
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr_in)
      sbg_pkg::ADDR_TX_CTRL: next_prdata = {24'h00_0000, transmit_control_status};
      sbg_pkg::ADDR_RX_CTRL: next_prdata = {24'h00_0000, receive_control_status};
      sbg_pkg::ADDR_BAUD_CTRL: next_prdata = {24'h00_0000, baud_control};
      sbg_pkg::ADDR_DIV_HIGH: next_prdata = {24'h00_0000, baud_divisor_high};
      sbg_pkg::ADDR_DIV_LOW: next_prdata = {24'h00_0000, baud_divisor_low};
      sbg_pkg::ADDR_STATUS: next_prdata = {23'h0, smp.level, 2'h0, prescale};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup) begin
      prdata_out <= next_prdata;
    end
  end

  // Register file writes
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      transmit_control_status <= sbg_pkg::TX_CTRL_RESET;
      receive_control_status <= sbg_pkg::RX_CTRL_RESET;
      baud_control <= sbg_pkg::BAUD_CTRL_RESET;
      baud_divisor_high <= sbg_pkg::DIV_RESET;
      baud_divisor_low <= sbg_pkg::DIV_RESET;
    end else begin
      if (wr_tx) transmit_control_status <= pwdata_in[7:0];
      if (wr_rx) receive_control_status <= pwdata_in[7:0];
      if (wr_bc) baud_control <= pwdata_in[7:0];
      if (wr_hi) baud_divisor_high <= pwdata_in[7:0];
      if (wr_lo) baud_divisor_low <= pwdata_in[7:0];
    end
  end

  // Base divider: one tick every n+1 device clocks
  assign baud_tick = (count == div_n) && (prescale == last) && !wr_div;
  wire base_tick = (count == div_n);
  always_ff @(posedge clock_in) begin
    if (reset_in || wr_div) begin
      count <= '0;
      prescale <= 6'h00;
    end else if (base_tick) begin
      count <= '0;
      prescale <= (prescale >= last) ? 6'h00 : prescale + 6'h01;
    end else begin
      count <= count + DIV_W'(1);
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_in;
      rx_sync <= rx_meta;
    end
  end

  // Three strobes around mid-bit, vote on the last
  assign smp.rx_sync = rx_sync;
  assign smp.strobe = base_tick && !wr_div && (prescale == mid - 6'h01 || prescale == mid ||
                      prescale == mid + 6'h01);
  assign smp.vote = base_tick && !wr_div && prescale == mid + 6'h01;

  sbg_voter u_voter (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .smp(smp.voter)
  );

  // Outputs
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      baud_tick_out <= 1'b0;
    end else begin
      baud_tick_out <= baud_tick;
    end
  end
  assign rx_level_out = smp.level;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  property p_div_clear;
    wr_div |=> count == '0 && prescale == 6'h00 && !baud_tick_out;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divisor write did not clear");
  property p_wrap;
    base_tick && !wr_div |=> count == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at divisor");
  property p_async64;
    !sync_mode && !wide_divisor_select && !high_speed_select |-> last == sbg_pkg::LAST_DIV64;
  endproperty
  a_async64: assert property (p_async64) else $error("low speed factor not 64");
  property p_mixed16;
    !sync_mode && (wide_divisor_select ^ high_speed_select) |-> last == sbg_pkg::LAST_DIV16;
  endproperty
  a_mixed16: assert property (p_mixed16) else $error("factor not 16");
  property p_sync4;
    sync_mode |-> last == sbg_pkg::LAST_DIV4;
  endproperty
  a_sync4: assert property (p_sync4) else $error("sync factor not 4");
  property p_both4;
    !sync_mode && wide_divisor_select && high_speed_select |-> last == sbg_pkg::LAST_DIV4;
  endproperty
  a_both4: assert property (p_both4) else $error("fast wide factor not 4");
  property p_narrow;
    !wide_divisor_select |-> div_n == DIV_W'(baud_divisor_low);
  endproperty
  a_narrow: assert property (p_narrow) else $error("high byte used in narrow mode");
  property p_low_write;
    wr_lo |=> baud_divisor_low == $past(pwdata_in[7:0]) && $stable(baud_divisor_high);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte write wrong");
  property p_tick_cause;
    baud_tick_out |-> $past(count) == $past(div_n) && $past(prescale) == $past(last);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("baud tick without wrap");
  // Tick width, high byte write and vote placement
  property p_tick_single;
    baud_tick_out |=> !baud_tick_out;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too long");
  property p_high_write;
    wr_hi |=> baud_divisor_high == $past(pwdata_in[7:0]) && $stable(baud_divisor_low);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high byte write wrong");
  property p_vote_on_strobe;
    smp.vote |-> smp.strobe;
  endproperty
  a_vote_on_strobe: assert property (p_vote_on_strobe) else $error("vote without sample");
endmodule

/* File: verif/sbg_remote_dev.sv */
// Purpose: Remote serial device that drives the receive pin
// Assumes: The line idles high between frames
// Notes: The level changes only just after a clock edge
`timescale 1ns/1ps
module sbg_remote_dev (
  input wire logic clock_in,
  input wire logic level_in,
  output logic rx_out
);
  // Put the requested level on the line
  always_ff @(posedge clock_in) begin
    rx_out <= level_in;
  end
endmodule

/* File: verif/serial_baud_rate_generator_tb_top.sv */
// Purpose: Self-checking bench for the baud generator
// Assumes: APB answers without a fixed wait; one 250 MHz clock
// Notes: Periods are counted between consecutive ticks
`timescale 1ns/1ps
module serial_baud_rate_generator_tb_top;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic lvl = 1;
  logic e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, tick, rx, rxl;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  sbg_top uut (.clock_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .rx_in(rx), .baud_tick_out(tick),
    .rx_level_out(rxl));
  sbg_remote_dev peer (.clock_in(clk), .level_in(lvl), .rx_out(rx));
  // Clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      $display("ERROR at %0t: cycles %h limit %h", $time, cyc, 60000);
      end_sim();
    end
  end
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; result left in q and e
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Wait for the answer; only the hang limit ends this
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 5000);
    if (tick !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: tick %h expected %h", $time, tick, 1'b1);
    end
  endtask
  task automatic t_regs();
    apb(1'b0, sbg_pkg::ADDR_TX_CTRL, 32'h0);
    chk(q, {24'h0, sbg_pkg::TX_CTRL_RESET});
    chk({31'h0, e}, 32'h0);
    apb(1'b0, sbg_pkg::ADDR_BAUD_CTRL, 32'h0);
    chk(q, {24'h0, sbg_pkg::BAUD_CTRL_RESET});
    apb(1'b0, sbg_pkg::ADDR_DIV_LOW, 32'h0);
    chk(q, {24'h0, sbg_pkg::DIV_RESET});
    apb(1'b1, 8'h3c, 32'h77);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, sbg_pkg::ADDR_DIV_HIGH, 32'h5a);
    apb(1'b0, sbg_pkg::ADDR_DIV_HIGH, 32'h0);
    chk(q, 32'h5a);
  endtask
  // All mode combinations: bit0 high speed, bit1 wide, bit2 synchronous
  task automatic t_modes();
    int n, f, p;
    for (int i = 0; i < 8; i++) begin
      f = i[2] ? 4 : (i[1] && i[0]) ? 4 : (i[1] || i[0]) ? 16 : 64;
      n = i[1] ? 32'h0103 : 3;
      apb(1'b1, sbg_pkg::ADDR_TX_CTRL, {27'h0, i[2], 1'b0, i[0], 2'b00});
      apb(1'b1, sbg_pkg::ADDR_BAUD_CTRL, {28'h0, i[1], 3'h0});
      apb(1'b1, sbg_pkg::ADDR_DIV_HIGH, 32'h01);
      apb(1'b1, sbg_pkg::ADDR_DIV_LOW, 32'h02);
      wait_tick(p);
      wait_tick(p);
      chk(p, f * n);
    end
  endtask
  // New divisor must not wait out a long old count
  task automatic t_clear();
    int p;
    apb(1'b1, sbg_pkg::ADDR_TX_CTRL, 32'h0);
    apb(1'b1, sbg_pkg::ADDR_BAUD_CTRL, 32'h0);
    apb(1'b1, sbg_pkg::ADDR_DIV_LOW, 32'hff);
    repeat (200) @(posedge clk);
    apb(1'b1, sbg_pkg::ADDR_DIV_LOW, 32'h00);
    wait_tick(p);
    chk({31'h0, p <= 66}, 32'h1);
  endtask
  // One-cycle glitch is outvoted; a held low wins
  task automatic t_vote();
    int k;
    apb(1'b1, sbg_pkg::ADDR_TX_CTRL, 32'h10);
    apb(1'b1, sbg_pkg::ADDR_DIV_LOW, 32'h00);
    // Factor 4, n 0: the glitch reaches the sampler on the voting sample
    repeat (3) @(posedge clk);
    lvl <= 1'b0;
    @(posedge clk);
    lvl <= 1'b1;
    k = 0;
    repeat (20) begin
      @(posedge clk);
      if (rxl !== 1'b1) begin
        k++;
      end
    end
    chk(k, 0);
    lvl <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rxl !== 1'b0 && k < 16);
    chk({31'h0, rxl}, 32'h0);
    lvl <= 1'b1;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs();
    t_modes();
    t_clear();
    t_vote();
    end_sim();
  end
endmodule
